// file: verilog/sps_pkg.sv
package sps_pkg;

  localparam int unsigned NUM_PINS = 16;
  localparam int unsigned NUM_IRQ  = 8;

  // pin positions of the shared functions
  localparam int unsigned PIN_I2C_DATA_A = 3;
  localparam int unsigned PIN_I2C_CLK_A  = 4;
  localparam int unsigned PIN_DEBUG      = 8;
  localparam int unsigned PIN_I2C_DATA_B = 9;
  localparam int unsigned PIN_BUZZER     = 10;
  localparam int unsigned PIN_AMP_POS    = 11;
  localparam int unsigned PIN_AMP_NEG    = 12;
  localparam int unsigned PIN_AMP_OUT    = 13;

  // buzzer frequency codes taken from the watch prescaler
  localparam logic [2:0] BUZ_WATCH_SRC_0 = 3'h5;
  localparam logic [2:0] BUZ_WATCH_SRC_1 = 3'h6;
  localparam logic [2:0] BUZ_WATCH_SRC_2 = 3'h7;

  localparam logic [NUM_PINS-1:0] PINS_ALL_ONE = 16'hFFFF;
  localparam logic [NUM_PINS-1:0] PINS_ZERO    = 16'h0000;
  localparam logic [NUM_PINS-NUM_IRQ-1:0] IRQ_PAD = 8'h00;

  typedef enum logic [4:0] {
    SPS_ST_RESET  = 5'h01,
    SPS_ST_RUN    = 5'h02,
    SPS_ST_SLEEP  = 5'h04,
    SPS_ST_STOP   = 5'h08,
    SPS_ST_WATCH  = 5'h10
  } sps_state_t;

endpackage : sps_pkg

// file: verilog/sps_pin_ctrl.sv
module sps_pin_ctrl
  import sps_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          sleep_mode,
  input  wire logic                          stop_mode,
  input  wire logic                          watch_mode,
  input  wire logic                          standby_float_select,
  input  wire logic [sps_pkg::NUM_PINS-1:0]  port_dout,
  input  wire logic [sps_pkg::NUM_PINS-1:0]  port_drive,
  input  wire logic [sps_pkg::NUM_PINS-1:0]  pad_in,
  input  wire logic [sps_pkg::NUM_IRQ-1:0]   ext_irq_enable,
  input  wire logic                          i2c_on_pins_a,
  input  wire logic                          i2c_on_pins_b,
  input  wire logic                          i2c_wake_enable,
  input  wire logic                          on_chip_debug_mode,
  input  wire logic [2:0]                    buzzer_freq_select,
  input  wire logic                          analog_amplifier_enable,
  output logic      [sps_pkg::NUM_PINS-1:0]  pad_out,
  output logic      [sps_pkg::NUM_PINS-1:0]  pad_oe_n,
  output logic      [sps_pkg::NUM_PINS-1:0]  in_gate_en,
  output logic      [sps_pkg::NUM_PINS-1:0]  core_in
);
  import sps_pkg::*;

  function automatic logic is_watch_src(input logic [2:0] sel);
    is_watch_src = (sel == BUZ_WATCH_SRC_0) || (sel == BUZ_WATCH_SRC_1) ||
                   (sel == BUZ_WATCH_SRC_2);
  endfunction : is_watch_src

  function automatic logic [NUM_PINS-1:0] pin_bit(input int unsigned idx);
    logic [NUM_PINS-1:0] m;
    m      = PINS_ZERO;
    m[idx] = 1'b1;
    pin_bit = m;
  endfunction : pin_bit

  sps_state_t          state_ff;
  sps_state_t          nxt_state;
  logic [NUM_PINS-1:0] hold_dout_ff;
  logic [NUM_PINS-1:0] hold_drive_ff;
  logic [NUM_PINS-1:0] pad_out_ff;
  logic [NUM_PINS-1:0] pad_oe_n_ff;
  logic [NUM_PINS-1:0] in_gate_en_ff;
  logic [NUM_PINS-1:0] core_in_ff;
  logic                standby;
  logic [NUM_PINS-1:0] irq_m;
  logic [NUM_PINS-1:0] live_m;
  logic [NUM_PINS-1:0] gate_m;
  logic [NUM_PINS-1:0] amp_m;
  logic [NUM_PINS-1:0] nxt_out;
  logic [NUM_PINS-1:0] nxt_oe_n;

  always_comb begin
    case (1'b1)
      stop_mode:  nxt_state = SPS_ST_STOP;
      watch_mode: nxt_state = SPS_ST_WATCH;
      sleep_mode: nxt_state = SPS_ST_SLEEP;
      default:    nxt_state = SPS_ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SPS_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    case (state_ff)
      SPS_ST_STOP:  standby = 1'b1;
      SPS_ST_WATCH: standby = 1'b1;
      default:      standby = 1'b0;
    endcase
  end

  assign irq_m = {IRQ_PAD, ext_irq_enable};
  assign amp_m = pin_bit(PIN_AMP_POS) | pin_bit(PIN_AMP_NEG) | pin_bit(PIN_AMP_OUT);

  // pins that keep their live function through standby
  always_comb begin
    live_m = PINS_ZERO;
    if (on_chip_debug_mode) begin
      live_m = live_m | pin_bit(PIN_DEBUG);
    end
    if (analog_amplifier_enable) begin
      live_m = live_m | amp_m;
    end
    if (!standby_float_select && is_watch_src(buzzer_freq_select)) begin
      live_m = live_m | pin_bit(PIN_BUZZER);
    end
  end

  // input gates left open in standby
  always_comb begin
    gate_m = live_m & ~pin_bit(PIN_BUZZER);
    gate_m = gate_m | irq_m;
    if (i2c_on_pins_a && i2c_wake_enable) begin
      gate_m = gate_m | pin_bit(PIN_I2C_DATA_A) | pin_bit(PIN_I2C_CLK_A);
    end
    if (i2c_on_pins_b && i2c_wake_enable) begin
      gate_m = gate_m | pin_bit(PIN_DEBUG) | pin_bit(PIN_I2C_DATA_B);
    end
  end

  // last driven state captured while not in standby
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_dout_ff  <= PINS_ZERO;
      hold_drive_ff <= PINS_ZERO;
    end else if (!standby) begin
      hold_dout_ff  <= port_dout;
      hold_drive_ff <= port_drive;
    end
  end

  always_comb begin
    if (standby && standby_float_select) begin
      nxt_out  = (port_dout & live_m) | (hold_dout_ff & ~live_m);
      nxt_oe_n = ~(port_drive & live_m);
    end else if (standby) begin
      nxt_out  = (port_dout & live_m) | (hold_dout_ff & ~live_m);
      nxt_oe_n = ~((port_drive & live_m) | (hold_drive_ff & ~live_m));
    end else begin
      nxt_out  = port_dout;
      nxt_oe_n = ~port_drive;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_ff == SPS_ST_RESET) begin
      pad_out_ff    <= PINS_ZERO;
      pad_oe_n_ff   <= PINS_ALL_ONE;
      in_gate_en_ff <= PINS_ALL_ONE;
      core_in_ff    <= PINS_ZERO;
    end else begin
      pad_out_ff    <= nxt_out;
      pad_oe_n_ff   <= nxt_oe_n;
      in_gate_en_ff <= standby ? gate_m : PINS_ALL_ONE;
      core_in_ff    <= pad_in & (standby ? gate_m : PINS_ALL_ONE);
    end
  end

  assign pad_out    = pad_out_ff;
  assign pad_oe_n   = pad_oe_n_ff;
  assign in_gate_en = in_gate_en_ff;
  assign core_in    = core_in_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence retain_s;
    standby && !standby_float_select ##1 standby && !standby_float_select;
  endsequence

  sequence sleeping_s;
    state_ff == SPS_ST_SLEEP;
  endsequence

  retain_hold_a: assert property (
    retain_s |=> ((pad_out_ff ^ $past(pad_out_ff)) & ~$past(live_m) & ~$past(live_m, 2))
                 == PINS_ZERO)
    else $error("retained pin output changed in standby");

  float_hiz_a: assert property (
    standby && standby_float_select |=> (pad_oe_n_ff | $past(live_m)) == PINS_ALL_ONE)
    else $error("floating pin still driven in standby");

  input_cut_a: assert property (
    standby |=> (core_in_ff & ~$past(gate_m)) == PINS_ZERO)
    else $error("cut-off pin reached internal logic");

  reset_state_a: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> pad_oe_n_ff == PINS_ALL_ONE && in_gate_en_ff == PINS_ALL_ONE &&
            core_in_ff == PINS_ZERO)
    else $error("pin not floating with gate enabled in reset");

  irq_gate_a: assert property (
    standby |=> (in_gate_en_ff & $past(irq_m)) == $past(irq_m))
    else $error("interrupt pin input cut in standby");

  i2c_pair_a_a: assert property (
    standby && i2c_on_pins_a && i2c_wake_enable |=>
      in_gate_en_ff[PIN_I2C_DATA_A] && in_gate_en_ff[PIN_I2C_CLK_A])
    else $error("first i2c pair input cut in standby");

  i2c_pair_b_a: assert property (
    standby && i2c_on_pins_b && i2c_wake_enable |=>
      in_gate_en_ff[PIN_DEBUG] && in_gate_en_ff[PIN_I2C_DATA_B])
    else $error("alternate i2c pair input cut in standby");

  debug_pin_a: assert property (
    standby && on_chip_debug_mode |=> in_gate_en_ff[PIN_DEBUG] &&
      pad_out_ff[PIN_DEBUG] == $past(port_dout[PIN_DEBUG]) &&
      pad_oe_n_ff[PIN_DEBUG] == !$past(port_drive[PIN_DEBUG]))
    else $error("debug pin not live in standby");

  buzzer_live_a: assert property (
    standby && !standby_float_select && is_watch_src(buzzer_freq_select) |=>
      pad_out_ff[PIN_BUZZER] == $past(port_dout[PIN_BUZZER]) &&
      pad_oe_n_ff[PIN_BUZZER] == !$past(port_drive[PIN_BUZZER]))
    else $error("buzzer pin stopped in standby");

  amp_pins_a: assert property (
    standby && analog_amplifier_enable |=>
      (in_gate_en_ff & amp_m) == amp_m &&
      (pad_out_ff & amp_m) == ($past(port_dout) & amp_m) &&
      (pad_oe_n_ff & amp_m) == (~$past(port_drive) & amp_m))
    else $error("amplifier pins not functional in standby");

  sleep_normal_a: assert property (
    sleeping_s |=> pad_out_ff == $past(port_dout) && pad_oe_n_ff == ~$past(port_drive) &&
                   in_gate_en_ff == PINS_ALL_ONE && core_in_ff == $past(pad_in))
    else $error("sleep mode pin behaviour differs from normal");

endmodule : sps_pin_ctrl

// file: testbench/sps_board.sv
module sps_board
  import sps_pkg::*;
(
  input  wire logic [sps_pkg::NUM_PINS-1:0] pad_out,
  input  wire logic [sps_pkg::NUM_PINS-1:0] pad_oe_n,
  input  wire logic [sps_pkg::NUM_PINS-1:0] pull_level,
  output logic      [sps_pkg::NUM_PINS-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released pad settles to its board pull level, never to the last driven value
  always_comb pad_in = (pad_out & ~pad_oe_n) | (pull_level & pad_oe_n);
endmodule : sps_board

// file: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sps_pkg::*;
  `define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
  logic        clk, rst, sleep, stop, watch, fl, ia, ib, iw, dbg, amp;
  logic [15:0] dout, drive, pad_in, pad_out, pad_oe_n, in_gate_en, core_in;
  logic [7:0]  eirq;
  logic [2:0]  buz;
  int          bad_count, n_compared, cycles;

  sps_pin_ctrl i_dut (.clk(clk), .rst(rst), .sleep_mode(sleep), .stop_mode(stop),
    .watch_mode(watch), .standby_float_select(fl), .port_dout(dout), .port_drive(drive),
    .pad_in(pad_in), .ext_irq_enable(eirq), .i2c_on_pins_a(ia), .i2c_on_pins_b(ib),
    .i2c_wake_enable(iw), .on_chip_debug_mode(dbg), .buzzer_freq_select(buz),
    .analog_amplifier_enable(amp), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .in_gate_en(in_gate_en), .core_in(core_in));
  sps_board i_board (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_level(16'h0F0F),
    .pad_in(pad_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("mismatches %0d comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cycles++;
    if (cycles == 600) begin
      bad_count++;
      results();
    end
  end

  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // mode word is {stop, watch, sleep, float select}; mode reaches the pins in two edges
  task go(input logic [3:0] m);
    {stop, watch, sleep, fl} = m;
    wt(3);
  endtask : go

  task chk(input logic [15:0] eo, input logic [15:0] eoe, input logic [15:0] eg);
    `CHK("pad_out", eo & ~eoe, pad_out & ~eoe)
    `CHK("pad_oe_n", eoe, pad_oe_n)
    `CHK("in_gate_en", eg, in_gate_en)
    `CHK("core_in", pad_in & eg, core_in)
  endtask : chk

  initial begin
    {rst, sleep, stop, watch, fl, ia, ib, iw, dbg, amp} = 10'h200;
    {dout, drive, eirq, buz} = {16'hA5C3, 16'hFFFF, 8'h00, 3'h0};
    wt(12);
    `CHK("reset oe_n", 16'hFFFF, pad_oe_n)
    `CHK("reset gate", 16'hFFFF, in_gate_en)
    `CHK("reset core_in", 16'h0000, core_in)
    rst = 1'b0;
    go(4'b0000);
    chk(16'hA5C3, 16'h0000, 16'hFFFF);
    go(4'b0010);
    chk(16'hA5C3, 16'h0000, 16'hFFFF);
    go(4'b1000);
    dout = 16'h5A3C;
    wt(2);
    chk(16'hA5C3, 16'h0000, 16'h0000);
    go(4'b1001);
    chk(16'h0000, 16'hFFFF, 16'h0000);
    go(4'b0000);
    {eirq, ia, iw} = {8'h81, 1'b1, 1'b1};
    go(4'b0100);
    chk(16'h5A3C, 16'h0000, 16'h0099);
    {ia, ib} = 2'b01;
    wt(2);
    chk(16'h5A3C, 16'h0000, 16'h0381);
    {eirq, ib, dbg, dout} = {8'h00, 1'b0, 1'b1, 16'hFFFF};
    wt(2);
    chk(16'h5B3C, 16'h0000, 16'h0100);
    {dbg, amp} = 2'b01;
    wt(2);
    chk(16'h7A3C, 16'h0000, 16'h3800);
    amp = 1'b0;
    for (int c = 4; c < 8; c++) begin
      buz = c[2:0];
      wt(2);
      chk((c > 4) ? 16'h5E3C : 16'h5A3C, 16'h0000, 16'h0000);
    end
    // float select 1 in watch mode: buzzer and retained pins both release
    go(4'b0101);
    chk(16'h0000, 16'hFFFF, 16'h0000);
    // reset taken from standby must override the retained state
    rst = 1'b1;
    wt(2);
    `CHK("standby reset oe_n", 16'hFFFF, pad_oe_n)
    `CHK("standby reset gate", 16'hFFFF, in_gate_en)
    `CHK("standby reset core_in", 16'h0000, core_in)
    results();
  end
endmodule : testbench
